// [inc/pdpa_pkg.sv]
/*
 * Shared constants and carrier types for the post divider / phase align block.
 * Assumes a single 100 MHz system clock and Avalon-MM register access.
 */
package pdpa_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int MOD_W = 4;
	localparam int POS_W = 12;
	localparam int FBK_W = 14;

	// byte offsets of the register words
	localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_POSTDIV = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_FBKDIV = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_STATE = 5'h0c;
	localparam logic [ADDR_W-1:0] OFS_EVENT = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_MASK = 5'h14;

	// control and post divider word field positions
	localparam int CTRL_SLIP = 0;
	localparam int CTRL_FBSRC = 1;
	localparam int CTRL_PUSHPULL = 2;
	localparam int CTRL_MODE_LO = 3;
	localparam int CTRL_MODE_HI = 4;
	localparam int CTRL_COARSE_LSB = 8;
	localparam int CTRL_FINE = 12;
	localparam int POSTDIV_N1_LSB = 0;
	localparam int POSTDIV_N2_LSB = 4;
	localparam int POSTDIV_N3_LSB = 8;

	// event bits, same layout in event and mask registers
	localparam int EVT_W = 3;
	localparam int EVT_ALIGN = 0;
	localparam int EVT_LOCK_LOST = 1;
	localparam int EVT_SLIP_DONE = 2;

	localparam logic [MOD_W-1:0] MOD_RESET = 4'h1;
	localparam logic [FBK_W-1:0] FBK_RESET = 14'h0008;
	localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		PDPA_MODE_LOCK = 2'b00,
		PDPA_MODE_RANGE = 2'b01,
		PDPA_MODE_ALIGN = 2'b10,
		PDPA_MODE_FBMON = 2'b11
	} pdpa_mode_type;

	typedef struct packed {
		logic fine_tune_enable;
		logic [3:0] crystal_coarse_tune;
		pdpa_mode_type mode;
		logic push_pull_select;
		logic feedback_source_select;
		logic phase_slip_toggle;
	} pdpa_ctrl_type;

	typedef struct packed {
		logic [MOD_W-1:0] n3;
		logic [MOD_W-1:0] n2;
		logic [MOD_W-1:0] n1;
	} pdpa_postdiv_type;

	typedef struct packed {
		logic clock_out_true;
		logic clock_out_comp;
	} pdpa_clkout_type;

	typedef struct packed {
		logic status_pin;
		logic status_pin_oe_n;
	} pdpa_pin_type;
endpackage

// [design/pdpa_top.sv]
/*
 * Post divider, clock gobbler, feedback source switch, phase sampling,
 * status pin multiplexer and crystal tune controls, behind Avalon-MM.
 * Assumes the VCO runs at half the system clock (one VCO period is two
 * sys_clk cycles) and that analog pins arrive asynchronously.
 */
//
// Operation
// R01 - three cascaded dividers, total modulus is product
// R02 - output equals reference times feedback over dividers
// R03 - odd modulus still gives equal high/low time
// R04 - gobbler suppresses one VCO pulse before post divider
// R05 - each rising slip-bit edge delays one VCO period
// R06 - select feeds feedback divider from VCO or post
// R07 - software keeps feedback modulus a post-modulus multiple
// R08 - feedback source clock samples output clock
// R09 - alignment detected toggles the phase-align flag
// R10 - mode 10 with push-pull drives flag on pin
// R11 - mode 10 readback upper mode bit shows flag
// R12 - mode 11 drives feedback divider clock on pin
// R13 - pin driven only while push-pull select set
// R14 - four-bit coarse code drives oscillator load trim
// R15 - fine tune enable bit gates voltage tuning
// R16 - mode 00 shows crystal lock flag, pin and readback
// R17 - mode 01 shows range direction, latched on lock loss
// R18 - slip bit edge detected once in VCO timing
`timescale 1ns/100ps

module pdpa_top
	import pdpa_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic [pdpa_pkg::ADDR_W-1:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [3:0] byteenable_i,
	input wire logic [pdpa_pkg::DATA_W-1:0] writedata_i,
	output logic [pdpa_pkg::DATA_W-1:0] readdata_o,
	output logic waitrequest_o,
	output logic irq_o,
	input wire logic feedback_source_clock_i,
	input wire logic crystal_lock_i,
	input wire logic crystal_range_high_i,
	input wire logic status_pin_i,
	output pdpa_pkg::pdpa_pin_type status_pin_o,
	output pdpa_pkg::pdpa_clkout_type clock_out_o,
	output logic feedback_divider_clock_o,
	output logic [3:0] crystal_coarse_tune_o,
	output logic fine_tune_enable_o
);
	import pdpa_pkg::*;

	function automatic logic [MOD_W-1:0] eff_mod(input logic [MOD_W-1:0] m);
		eff_mod = (m == '0) ? MOD_RESET : m;
	endfunction

	function automatic logic [DATA_W-1:0] be_merge(input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v, input logic [3:0] be);
		logic [DATA_W-1:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		be_merge = r;
	endfunction

	pdpa_ctrl_type ctrl;
	pdpa_postdiv_type postdiv;
	logic [FBK_W-1:0] fbk_mod, fbk_cnt, fbk_eff;
	logic [EVT_W-1:0] evt_stat, evt_mask;
	logic [DATA_W-1:0] next_readdata, ctrl_word, postdiv_word, ctrl_merged;
	logic bus_take;

	// two-flop synchronisers for asynchronous pins
	logic [1:0] fbs_sync, lock_sync, range_sync, pin_sync;
	logic fbs_prev, lock_prev, lock_lost, range_latch;

	logic vco_phase, vco_tick, slip_prev, slip_pending, advance;
	logic [MOD_W-1:0] c1, c2, c3, n1, n2, n3;
	logic [POS_W-1:0] total_mod, position;
	logic out_q, out_prev, fbk_src_evt, fbk_clk;
	logic sample_q, align_flag, align_evt, mode_hi_view, next_pin;

	assign bus_take = (read_i | write_i) & ~waitrequest_o;
	assign ctrl_merged = be_merge(ctrl_word, writedata_i, byteenable_i);

	// avalon handshake: waitrequest drops for one cycle, transfer at that edge
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			waitrequest_o <= 1'b1;
		end else begin
			waitrequest_o <= ~((read_i | write_i) & waitrequest_o);
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			readdata_o <= READ_ZERO;
		end else if (read_i & waitrequest_o) begin
			readdata_o <= next_readdata;
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl <= '0;
			postdiv <= {MOD_RESET, MOD_RESET, MOD_RESET};
			fbk_mod <= FBK_RESET;
			evt_mask <= '0;
		end else if (write_i & bus_take) begin
			case (address_i)
				OFS_CTRL: begin
					// fields unpacked one by one: register layout has gaps
					ctrl <= {ctrl_merged[CTRL_FINE], ctrl_merged[CTRL_COARSE_LSB +: 4],
						ctrl_merged[CTRL_MODE_HI], ctrl_merged[CTRL_MODE_LO],
						ctrl_merged[CTRL_PUSHPULL], ctrl_merged[CTRL_FBSRC],
						ctrl_merged[CTRL_SLIP]};
				end
				OFS_POSTDIV: begin
					postdiv <= pdpa_postdiv_type'(be_merge(postdiv_word, writedata_i,
						byteenable_i));
				end
				OFS_FBKDIV: begin
					fbk_mod <= FBK_W'(be_merge({{(DATA_W-FBK_W){1'b0}}, fbk_mod},
						writedata_i, byteenable_i));
				end
				OFS_MASK: begin
					evt_mask <= EVT_W'(be_merge({{(DATA_W-EVT_W){1'b0}}, evt_mask},
						writedata_i, byteenable_i));
				end
				default: begin
				end
			endcase
		end
	end

	// stored words in register layout
	always_comb begin
		ctrl_word = '0;
		ctrl_word[CTRL_SLIP] = ctrl.phase_slip_toggle;
		ctrl_word[CTRL_FBSRC] = ctrl.feedback_source_select;
		ctrl_word[CTRL_PUSHPULL] = ctrl.push_pull_select;
		ctrl_word[CTRL_MODE_LO] = ctrl.mode[0];
		ctrl_word[CTRL_MODE_HI] = ctrl.mode[1];
		ctrl_word[CTRL_COARSE_LSB +: 4] = ctrl.crystal_coarse_tune;
		ctrl_word[CTRL_FINE] = ctrl.fine_tune_enable;
		postdiv_word = '0;
		postdiv_word[POSTDIV_N1_LSB +: MOD_W] = postdiv.n1;
		postdiv_word[POSTDIV_N2_LSB +: MOD_W] = postdiv.n2;
		postdiv_word[POSTDIV_N3_LSB +: MOD_W] = postdiv.n3;
	end

	// upper mode bit readback replaced by the monitored flag in modes 00 to 10
	always_comb begin
		case (ctrl.mode)
			PDPA_MODE_LOCK: mode_hi_view = lock_sync[1]; // [R16]
			PDPA_MODE_RANGE: mode_hi_view = range_latch; // [R17]
			PDPA_MODE_ALIGN: mode_hi_view = align_flag; // [R11]
			default: mode_hi_view = ctrl.mode[1];
		endcase
	end

	always_comb begin
		next_readdata = READ_ZERO;
		case (address_i)
			OFS_CTRL: begin
				next_readdata = ctrl_word;
				next_readdata[CTRL_MODE_HI] = mode_hi_view;
			end
			OFS_POSTDIV: next_readdata = postdiv_word;
			OFS_FBKDIV: next_readdata[FBK_W-1:0] = fbk_mod;
			OFS_STATE: next_readdata[3:0] = {pin_sync[1], range_latch, lock_sync[1],
				align_flag};
			OFS_EVENT: next_readdata[EVT_W-1:0] = evt_stat;
			OFS_MASK: next_readdata[EVT_W-1:0] = evt_mask;
			default: next_readdata = READ_ZERO;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fbs_sync <= '0;
			lock_sync <= '0;
			range_sync <= '0;
			pin_sync <= '0;
			fbs_prev <= 1'b0;
			lock_prev <= 1'b0;
		end else begin
			fbs_sync <= {fbs_sync[0], feedback_source_clock_i};
			lock_sync <= {lock_sync[0], crystal_lock_i};
			range_sync <= {range_sync[0], crystal_range_high_i};
			pin_sync <= {pin_sync[0], status_pin_i};
			fbs_prev <= fbs_sync[1];
			lock_prev <= lock_sync[1];
		end
	end

	assign lock_lost = lock_prev & ~lock_sync[1];

	// vco rate is an enable every second system clock
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			vco_phase <= 1'b0;
		end else begin
			vco_phase <= ~vco_phase;
		end
	end

	assign vco_tick = ~vco_phase;

	// clock gobbler: one swallowed vco pulse per rising slip-bit change
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			slip_prev <= 1'b0;
			slip_pending <= 1'b0;
		end else begin
			slip_prev <= ctrl.phase_slip_toggle;
			if (ctrl.phase_slip_toggle & ~slip_prev) begin
				slip_pending <= 1'b1; // [R18] [R05]
			end else if (vco_tick) begin
				slip_pending <= 1'b0;
			end
		end
	end

	assign advance = vco_tick & ~slip_pending; // [R04] [R05]

	assign n1 = eff_mod(postdiv.n1);
	assign n2 = eff_mod(postdiv.n2);
	assign n3 = eff_mod(postdiv.n3);
	assign total_mod = POS_W'(n1) * POS_W'(n2) * POS_W'(n3); // [R01]
	assign position = (POS_W'(c3) * POS_W'(n2) + POS_W'(c2)) * POS_W'(n1) + POS_W'(c1);

	// cascaded stage counters
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			c1 <= '0;
			c2 <= '0;
			c3 <= '0;
		end else if (advance) begin
			if (c1 >= n1 - MOD_W'(1)) begin
				c1 <= '0; // [R01]
				if (c2 >= n2 - MOD_W'(1)) begin
					c2 <= '0;
					c3 <= (c3 >= n3 - MOD_W'(1)) ? '0 : c3 + MOD_W'(1);
				end else begin
					c2 <= c2 + MOD_W'(1);
				end
			end else begin
				c1 <= c1 + MOD_W'(1);
			end
		end
	end

	// half-vco resolution keeps odd totals at equal high and low
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			out_q <= 1'b0;
			out_prev <= 1'b0;
			clock_out_o <= '{clock_out_true: 1'b0, clock_out_comp: 1'b1};
		end else begin
			// inverted phase makes the half-vco index count upwards
			out_q <= {position, ~vco_phase} < {1'b0, total_mod}; // [R03] [R02]
			out_prev <= out_q;
			clock_out_o.clock_out_true <= out_q;
			clock_out_o.clock_out_comp <= ~out_q;
		end
	end

	// feedback divider source switch
	assign fbk_src_evt = ctrl.feedback_source_select ? (out_q & ~out_prev) : vco_tick; // [R06]
	assign fbk_eff = (fbk_mod == '0) ? FBK_W'(1) : fbk_mod;

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fbk_cnt <= '0;
			fbk_clk <= 1'b0;
		end else begin
			if (fbk_src_evt) begin
				fbk_cnt <= (fbk_cnt >= fbk_eff - FBK_W'(1)) ? '0 : fbk_cnt + FBK_W'(1);
			end
			fbk_clk <= fbk_cnt < (fbk_eff >> 1); // [R07]
		end
	end

	// phase sampling on feedback source rising edge
	assign align_evt = fbs_sync[1] & ~fbs_prev & out_q & ~sample_q;

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sample_q <= 1'b0;
			align_flag <= 1'b0;
		end else if (fbs_sync[1] & ~fbs_prev) begin
			sample_q <= out_q; // [R08]
			if (align_evt) begin
				align_flag <= ~align_flag; // [R09]
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			range_latch <= 1'b0;
		end else if (lock_lost) begin
			range_latch <= range_sync[1]; // [R17]
		end
	end

	// sticky events, cleared by reading, set wins over clear
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			evt_stat <= '0;
		end else begin
			for (int i = 0; i < EVT_W; i++) begin
				if ((i == EVT_ALIGN && align_evt) || (i == EVT_LOCK_LOST && lock_lost) ||
					(i == EVT_SLIP_DONE && vco_tick && slip_pending)) begin
					evt_stat[i] <= 1'b1;
				end else if (read_i && bus_take && address_i == OFS_EVENT) begin
					evt_stat[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(evt_stat & evt_mask);
		end
	end

	// status pin multiplexer
	always_comb begin
		case (ctrl.mode)
			PDPA_MODE_LOCK: next_pin = lock_sync[1]; // [R16]
			PDPA_MODE_RANGE: next_pin = range_latch; // [R17]
			PDPA_MODE_ALIGN: next_pin = align_flag; // [R10]
			PDPA_MODE_FBMON: next_pin = fbk_clk; // [R12]
			default: next_pin = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			status_pin_o <= '{status_pin: 1'b0, status_pin_oe_n: 1'b1};
			feedback_divider_clock_o <= 1'b0;
		end else begin
			status_pin_o.status_pin <= next_pin;
			status_pin_o.status_pin_oe_n <= ~ctrl.push_pull_select; // [R13] [R10]
			feedback_divider_clock_o <= fbk_clk;
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			crystal_coarse_tune_o <= '0;
			fine_tune_enable_o <= 1'b0;
		end else begin
			crystal_coarse_tune_o <= ctrl.crystal_coarse_tune; // [R14]
			fine_tune_enable_o <= ctrl.fine_tune_enable; // [R15]
		end
	end
endmodule

// [testbench/pdpa_props.sv]
/* port checker for pdpa_top
   bound to every pdpa_top instance, sees only its ports */
`timescale 1ns/100ps
module pdpa_props
	import pdpa_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic [pdpa_pkg::ADDR_W-1:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [pdpa_pkg::DATA_W-1:0] readdata_o,
	input wire logic waitrequest_o,
	input wire pdpa_pkg::pdpa_pin_type status_pin_o,
	input wire pdpa_pkg::pdpa_clkout_type clock_out_o,
	input wire logic [3:0] crystal_coarse_tune_o,
	input wire logic fine_tune_enable_o
);
	logic w_ctrl;
	assign w_ctrl = write_i && !waitrequest_o && address_i == OFS_CTRL;
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!reset_n_i);
	chk_wait_single: assert property (!waitrequest_o |=> waitrequest_o)
		else $error("waitrequest low too long");
	chk_wait_answer: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
		else $error("request not answered");
	chk_read_unmapped: assert property (read_i && !waitrequest_o && address_i > OFS_MASK
		|-> readdata_o == READ_ZERO) else $error("unmapped read not zero");
	chk_read_stands: assert property ($changed(readdata_o) |-> read_i && !waitrequest_o)
		else $error("read data moved");
	chk_clk_pair: assert property (clock_out_o.clock_out_true != clock_out_o.clock_out_comp)
		else $error("clock pair not complementary");
	chk_coarse_cause: assert property ($changed(crystal_coarse_tune_o)
		|-> $past(w_ctrl) || $past(w_ctrl, 2)) else $error("coarse tune moved alone");
	chk_fine_cause: assert property ($changed(fine_tune_enable_o)
		|-> $past(w_ctrl) || $past(w_ctrl, 2)) else $error("fine enable moved alone");
	chk_drive_cause: assert property ($changed(status_pin_o.status_pin_oe_n)
		|-> $past(w_ctrl) || $past(w_ctrl, 2)) else $error("pin enable moved alone");
endmodule
bind pdpa_top pdpa_props u_props (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
	.address_i(address_i), .read_i(read_i), .write_i(write_i), .readdata_o(readdata_o),
	.waitrequest_o(waitrequest_o), .status_pin_o(status_pin_o), .clock_out_o(clock_out_o),
	.crystal_coarse_tune_o(crystal_coarse_tune_o), .fine_tune_enable_o(fine_tune_enable_o));

// [testbench/pdpa_far.sv]
/* far side model: feedback source clock, crystal loop flags, pin wire
   assumes the bench commands lock, range and the clock run */
`timescale 1ns/100ps
module pdpa_far
	import pdpa_pkg::*;
#(parameter int HALF = 7)
(
	input wire logic sys_clk_i,
	input wire logic fb_run_i,
	input wire logic lock_cmd_i,
	input wire logic range_cmd_i,
	input wire pdpa_pkg::pdpa_pin_type status_pin_o,
	output logic feedback_source_clock_o,
	output logic crystal_lock_o,
	output logic crystal_range_high_o,
	output logic pin_wire_o
);
	int cnt = 0;
	logic last = 1'b0;
	initial begin
		feedback_source_clock_o = 1'b0;
		crystal_lock_o = 1'b1;
		crystal_range_high_o = 1'b0;
	end
	// source clock stands still unless running
	always @(posedge sys_clk_i) begin
		if (fb_run_i) begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1)
				feedback_source_clock_o <= ~feedback_source_clock_o;
		end
		crystal_lock_o <= lock_cmd_i;
		crystal_range_high_o <= range_cmd_i;
		if (!status_pin_o.status_pin_oe_n)
			last <= status_pin_o.status_pin;
	end
	// released pin shows the inverse of its last level
	assign pin_wire_o = status_pin_o.status_pin_oe_n ? ~last : status_pin_o.status_pin;
endmodule

// [testbench/tb_pdpa_top.sv]
/* self-checking bench for pdpa_top with far side model
   assumes one 100 MHz clock and an Avalon-MM master made of tasks */
`timescale 1ns/100ps
module tb_pdpa_top;
	import pdpa_pkg::*;
	logic sys_clk_i = 0, reset_n_i = 0, read_i = 0, write_i = 0;
	logic [ADDR_W-1:0] address_i = '0;
	logic [DATA_W-1:0] writedata_i = '0, readdata_o, rd, st, ctrl;
	logic waitrequest_o, irq_o, fb_clk, lock_pin, range_pin, pin_wire, fb_div, fine_o, f0;
	logic fb_run = 0, lock_cmd = 1, range_cmd = 0;
	logic [3:0] coarse_o;
	logic [11:0] pd;
	pdpa_pin_type pin_o;
	pdpa_clkout_type clk_o;
	int bad_count = 0, samples_checked = 0, seed = 26499, n, hi, per;
	time t0;
	pdpa_top u_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .address_i(address_i),
		.read_i(read_i), .write_i(write_i), .byteenable_i(4'hf), .writedata_i(writedata_i),
		.readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .irq_o(irq_o),
		.feedback_source_clock_i(fb_clk), .crystal_lock_i(lock_pin),
		.crystal_range_high_i(range_pin), .status_pin_i(pin_wire), .status_pin_o(pin_o),
		.clock_out_o(clk_o), .feedback_divider_clock_o(fb_div),
		.crystal_coarse_tune_o(coarse_o), .fine_tune_enable_o(fine_o));
	pdpa_far u_far (.sys_clk_i(sys_clk_i), .fb_run_i(fb_run), .lock_cmd_i(lock_cmd),
		.range_cmd_i(range_cmd), .status_pin_o(pin_o), .feedback_source_clock_o(fb_clk),
		.crystal_lock_o(lock_pin), .crystal_range_high_o(range_pin), .pin_wire_o(pin_wire));
	initial forever #5 sys_clk_i = ~sys_clk_i;
	task automatic finish_test();
		if (bad_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		address_i <= a;
		writedata_i <= d;
		write_i <= wr;
		read_i <= !wr;
		@(posedge sys_clk_i);
		while (waitrequest_o !== 1'b0)
			@(posedge sys_clk_i);
		rd = readdata_o;
		write_i <= 0;
		read_i <= 0;
		@(posedge sys_clk_i);
	endtask
	function automatic logic probe(input int s);
		probe = s == 0 ? clk_o.clock_out_true : s == 1 ? fb_div : pin_o.status_pin;
	endfunction
	task automatic wv(input int s, input logic v, output int c);
		c = 0;
		while (probe(s) !== v && c < 600) begin
			@(posedge sys_clk_i);
			c++;
		end
	endtask
	task automatic meas(input int s, output int h, output int p);
		int c;
		repeat (2) begin
			wv(s, 0, c);
			wv(s, 1, c);
			wv(s, 0, h);
			wv(s, 1, p);
		end
		p = p + h;
	endtask
	function automatic int tot(input logic [11:0] v);
		tot = 1;
		for (int i = 0; i < 3; i++)
			tot = tot * (v[4*i+:4] == 0 ? 1 : int'(v[4*i+:4]));
	endfunction
	function automatic logic exp_hi(input int m, input logic a);
		exp_hi = m == 0 ? 1'b0 : m == 2 ? a : 1'b1;
	endfunction
	initial begin
		repeat (30000) @(posedge sys_clk_i);
		bad_count++;
		finish_test();
	end
	initial begin
		repeat (10) @(posedge sys_clk_i);
		reset_n_i <= 1;
		@(posedge sys_clk_i);
		bus(0, OFS_POSTDIV, 0);
		check(rd, 32'h0000_0111);
		bus(0, OFS_FBKDIV, 0);
		check(rd, 32'h0000_0008);
		bus(0, 5'h18, 0);
		for (int i = 0; i < 6; i++) begin
			pd = i == 0 ? 12'h333 : i == 1 ? 12'h000 : 12'($random(seed)) & 12'h333;
			bus(1, OFS_POSTDIV, {20'h0, pd});
			meas(0, hi, per);
			check(hi, tot(pd));
			check(per, 2 * tot(pd));
		end
		bus(1, OFS_POSTDIV, 32'h0000_0114);
		bus(1, OFS_MASK, 32'h0000_0004);
		bus(0, OFS_EVENT, 0);
		for (int s = 1; s >= 0; s--) begin
			wv(0, 0, n);
			wv(0, 1, n);
			t0 = $time;
			bus(1, OFS_CTRL, 32'h0000_0002 | s);
			repeat (3) begin
				wv(0, 0, n);
				wv(0, 1, n);
			end
			check(32'(($time - t0) / 10), 24 + 2 * s);
			check(irq_o, s);
			bus(0, OFS_EVENT, 0);
			check(rd[EVT_SLIP_DONE], s);
		end
		meas(1, hi, per);
		check(per, 64);
		range_cmd <= 1;
		repeat (6) @(posedge sys_clk_i);
		lock_cmd <= 0;
		repeat (6) @(posedge sys_clk_i);
		range_cmd <= 0;
		repeat (6) @(posedge sys_clk_i);
		check(irq_o, 0);
		bus(0, OFS_EVENT, 0);
		check(rd[EVT_LOCK_LOST], 1);
		for (int m = 0; m < 4; m++) begin
			for (int pp = 0; pp < 2; pp++) begin
				ctrl = ($random(seed) & 32'h0000_1f00) | (m << 3) | (pp << 2);
				bus(1, OFS_CTRL, ctrl);
				repeat (4) @(posedge sys_clk_i);
				check(coarse_o, ctrl[11:8]);
				check(fine_o, ctrl[12]);
				check(pin_o.status_pin_oe_n, !pp);
				bus(0, OFS_STATE, 0);
				st = rd;
				check(st[2:1], 2'b10);
				bus(0, OFS_CTRL, 0);
				check(rd[CTRL_MODE_HI], exp_hi(m, st[0]));
				if (pp == 1 && m < 3) begin
					check(pin_o.status_pin, exp_hi(m, st[0]));
					check(st[3], exp_hi(m, st[0]));
				end
			end
		end
		bus(1, OFS_CTRL, 32'h0000_001c);
		meas(2, hi, per);
		check(per, 16);
		meas(1, hi, per);
		check(per, 16);
		bus(1, OFS_CTRL, 32'h0000_0014);
		bus(1, OFS_MASK, 32'h0000_0001);
		bus(0, OFS_EVENT, 0);
		bus(0, OFS_STATE, 0);
		f0 = rd[0];
		fb_run <= 1;
		n = 0;
		while (irq_o !== 1'b1 && n < 800) begin
			@(posedge sys_clk_i);
			n++;
		end
		fb_run <= 0;
		check(irq_o, 1);
		bus(0, OFS_STATE, 0);
		check(rd[0], !f0);
		bus(0, OFS_EVENT, 0);
		check(rd[EVT_ALIGN], 1);
		reset_n_i <= 0;
		repeat (3) @(posedge sys_clk_i);
		check(clk_o, 2'b01);
		check(waitrequest_o, 1);
		reset_n_i <= 1;
		@(posedge sys_clk_i);
		bus(0, OFS_POSTDIV, 0);
		check(rd, 32'h0000_0111);
		finish_test();
	end
endmodule
